// ==== hw/mon_pkg.sv ====
/*
 * shared constants for the hardware monitor: register indices, reset
 * values, field positions, fan timing and the temperature mode type.
 * assumes a 10 MHz aclk and 32-bit register words on AXI4-Lite.
 */
// Notes on behaviour
// - count reference ticks over one tach period
// - fan divisor 1/2/4/8, default 2
// - count equals 1.35e6 over rpm times divisor
// - separate divisor field per fan
// - setpoints are signed bytes, 1 C steps
// - default reading is 9-bit, half degree
// - extended mode may read 12-bit, sixteenth degree
// - hysteresis offset is 3-bit, 1 C steps
// - normal or extended, three modes; normal no alarm
// - normal repetitive re-fires above upper-release
// - normal one-time re-arms at upper-release
// - reset selects normal one-time mode
// - normal comparator follows upper setpoint, low ignored
// - extended flags clear by status or ext read
// - extended repetitive low/high re-fire within hysteresis
// - extended repetitive alarm until below crit minus hysteresis
// - extended one-time low re-arms above low plus hysteresis
// - extended one-time high re-arms at upper minus hysteresis
// - extended one-time alarm re-arms at crit minus hysteresis
// - extended comparator low releases above low plus hysteresis
// - extended comparator high and alarm release with hysteresis
// - intrusion input latches a status flag
// - two status, two mask regs, enable gates interrupt
// - alarm is temperature only, lives in ext reg
// - status read returns then clears flags
// - mask bit blocks interrupt, flag still records
// - fan flag when count exceeds its limit
package mon_pkg;

	// clock and fan reference timing
	localparam int CLK_HZ = 10_000_000;
	localparam int FAN_REF_HZ = 22_500;
	// divisor 2 counts at the reference rate, so the base tick is twice as fast
	localparam int FAN_TICK_CYC = CLK_HZ / (2 * FAN_REF_HZ);
	localparam int TICK_W = 12;
	localparam logic [7:0] FAN_CNT_MAX = 8'hff;

	// register indices; byte address is four times the index
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_TEMP = 8'h27;
	localparam logic [7:0] IDX_FAN_A_CNT = 8'h28;
	localparam logic [7:0] IDX_FAN_B_CNT = 8'h29;
	localparam logic [7:0] IDX_HIGH = 8'h39;
	localparam logic [7:0] IDX_HIHYST = 8'h3a;
	localparam logic [7:0] IDX_FAN_A_LIM = 8'h3b;
	localparam logic [7:0] IDX_FAN_B_LIM = 8'h3c;
	localparam logic [7:0] IDX_CONFIG = 8'h40;
	localparam logic [7:0] IDX_STAT1 = 8'h41;
	localparam logic [7:0] IDX_STAT2 = 8'h42;
	localparam logic [7:0] IDX_MASK1 = 8'h43;
	localparam logic [7:0] IDX_MASK2 = 8'h44;
	localparam logic [7:0] IDX_FANDIV = 8'h47;
	localparam logic [7:0] IDX_TEMP_CFG = 8'h4b;
	localparam logic [7:0] IDX_EXT1 = 8'h4c;
	localparam logic [7:0] IDX_LOW = 8'h50;
	localparam logic [7:0] IDX_CRIT = 8'h51;
	localparam logic [7:0] IDX_HYST = 8'h52;

	// reset values and writable masks
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h08;
	localparam logic [7:0] CFG_WR_MASK = 8'h2f;
	localparam logic [7:0] RST_FANDIV = 8'h50;
	localparam logic [7:0] FANDIV_WR_MASK = 8'hf0;
	localparam logic [7:0] RST_TEMP_CFG = 8'h01;
	localparam logic [7:0] RST_EXT1 = 8'h44;
	localparam logic [7:0] RST_HI_SET = 8'h7f;
	localparam logic [7:0] RST_LO_SET = 8'h80;
	localparam logic [7:0] RST_FAN_LIM = 8'hff;

	// field positions
	localparam int CFG_START = 0;
	localparam int CFG_INT_EN = 1;
	localparam int CFG_INT_CLR = 3;
	localparam int ST1_TEMP = 4;
	localparam int ST1_FAN_A = 6;
	localparam int ST1_FAN_B = 7;
	localparam int ST2_INTR = 4;
	localparam int ST2_TLOW = 7;
	localparam int FDIV_A_LSB = 4;
	localparam int FDIV_B_LSB = 6;
	localparam int TCFG_EXT = 2;
	localparam int TCFG_RES12 = 3;

	// temperature data widths
	localparam int TEMP_W = 12;
	localparam int CMP_W = 14;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {MODE_REPEAT, MODE_ONCE, MODE_COMPARE} temp_mode_t;

endpackage : mon_pkg

// ==== hw/fan_period_counter.sv ====
/*
 * one fan tachometer period counter with programmable divisor.
 * assumes tach is already synchronous to aclk.
 */
`timescale 1ns/100ps
module fan_period_counter (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tach,
	input wire logic [1:0] div_code,
	output logic [7:0] count
);
	logic tach_q;
	logic [mon_pkg::TICK_W-1:0] pre;
	logic [7:0] run;
	logic [mon_pkg::TICK_W-1:0] pre_top;
	logic rise;
	logic tick;

	// divisor stretches the tick: code 0..3 gives 1,2,4,8
	assign pre_top = mon_pkg::TICK_W'((mon_pkg::FAN_TICK_CYC << div_code) - 1);
	assign rise = tach && !tach_q;
	assign tick = (pre == pre_top);

	always_ff @(posedge aclk) begin
		if (!aresetn) tach_q <= 1'b0;
		else tach_q <= tach;
	end

	// prescaler restarts on each rising tach edge so every period starts aligned
	always_ff @(posedge aclk) begin
		if (!aresetn || rise || tick) pre <= '0;
		else pre <= pre + 1'b1;
	end

	// period counter, held at full scale for a slow or stopped fan
	always_ff @(posedge aclk) begin
		if (!aresetn || rise) run <= mon_pkg::RST_ZERO;
		else if (tick && run != mon_pkg::FAN_CNT_MAX) run <= run + 1'b1;
	end

	// result taken per period; a stalled fan shows full scale without an edge
	always_ff @(posedge aclk) begin
		if (!aresetn) count <= mon_pkg::FAN_CNT_MAX;
		else if (rise) count <= run;
		else if (run == mon_pkg::FAN_CNT_MAX) count <= mon_pkg::FAN_CNT_MAX;
	end

	fan_sat_a: assert property (@(posedge aclk) disable iff (!aresetn)
		run == mon_pkg::FAN_CNT_MAX && !rise |=> run == mon_pkg::FAN_CNT_MAX)
		else $error("fan counter left full scale without an edge");
	fan_edge_c: cover property (@(posedge aclk) disable iff (!aresetn)
		rise && run > 8'h00);

endmodule : fan_period_counter

// ==== hw/temp_fan_limit_irq.sv ====
/*
 * hardware monitor digital side: fan period counters, temperature
 * limit comparison, status and mask registers, interrupt and alarm.
 * assumes an AXI4-Lite master, a converter giving a one-cycle
 * conv_done with 12-bit signed data in sixteenths of a degree.
 */
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module temp_fan_limit_irq (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [mon_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [mon_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic tach_input_a,
	input wire logic tach_input_b,
	input wire logic conv_done,
	input wire logic [mon_pkg::TEMP_W-1:0] conv_data,
	input wire logic intrusion_input,
	output logic int_n,
	output logic critical_temp_alarm_n
);
	typedef logic signed [mon_pkg::CMP_W-1:0] cmp_t;

	logic [7:0] cfg, stat1, stat2, mask1, mask2, fandiv, tcfg, ext1_ctl;
	logic [7:0] high_sp, upper_release_setpoint, low_sp, critical_temp_setpoint;
	logic [2:0] hysteresis_offset;
	logic [7:0] fan_a_lim, fan_b_lim, fan_a_cnt, fan_b_cnt;
	logic [mon_pkg::TEMP_W-1:0] temp_data;
	logic crit_flag, hi_reg, lo_reg, cr_reg;
	logic [7:0] next_stat1, next_stat2;
	logic next_crit, hi_next, lo_next, cr_next;
	logic wr_fire, wr_en, rd_fire, rd_ok;
	logic rd_stat1, rd_stat2, rd_ext1;
	logic [7:0] wr_idx, rd_idx;
	logic [31:0] rd_word;
	logic running, conv_fire, ext, cmp_mode;
	mon_pkg::temp_mode_t mode;
	cmp_t d, th, thh, tl, tc;
	logic hi_enter, hi_leave, lo_enter, lo_leave, cr_enter, cr_leave;

	// any register that the map holds
	function automatic logic mapped(input logic [mon_pkg::ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		mapped = 1'b0;
		if (a[mon_pkg::ADDR_W-1:10] == '0) begin
			case (i)
				mon_pkg::IDX_TEMP, mon_pkg::IDX_FAN_A_CNT, mon_pkg::IDX_FAN_B_CNT,
				mon_pkg::IDX_HIGH, mon_pkg::IDX_HIHYST, mon_pkg::IDX_FAN_A_LIM,
				mon_pkg::IDX_FAN_B_LIM, mon_pkg::IDX_CONFIG, mon_pkg::IDX_STAT1,
				mon_pkg::IDX_STAT2, mon_pkg::IDX_MASK1, mon_pkg::IDX_MASK2,
				mon_pkg::IDX_FANDIV, mon_pkg::IDX_TEMP_CFG, mon_pkg::IDX_EXT1,
				mon_pkg::IDX_LOW, mon_pkg::IDX_CRIT, mon_pkg::IDX_HYST: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction : mapped

	// whole-degree setpoint widened to sixteenths, plus or minus the offset
	function automatic cmp_t to_cmp(input logic [7:0] sp, input logic [2:0] off,
			input logic sub);
		cmp_t base, hy;
		base = {{2{sp[7]}}, sp, 4'h0};
		hy = {7'h00, off, 4'h0};
		to_cmp = sub ? base - hy : base + hy;
	endfunction : to_cmp

	// region held from entry until the leave condition
	function automatic logic region(input logic enter, input logic leave,
			input logic prev);
		region = enter || (prev && !leave);
	endfunction : region

	// sticky flag: comparator follows the region, repetitive sets while in it, one-time sets on entry
	function automatic logic upd(input logic flag, input logic clr, input logic conv,
			input mon_pkg::temp_mode_t m, input logic enter, input logic prev,
			input logic nxt);
		logic set;
		case (m)
			mon_pkg::MODE_REPEAT: set = nxt;
			mon_pkg::MODE_ONCE: set = enter && !prev;
			default: set = nxt;
		endcase
		if (conv && m != mon_pkg::MODE_REPEAT && m != mon_pkg::MODE_ONCE) upd = nxt;
		else upd = (flag && !clr) || (conv && set);
	endfunction : upd

	// the two fans, each with its own divisor field
	fan_period_counter fan_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.tach(tach_input_a),
		.div_code(fandiv[mon_pkg::FDIV_A_LSB +: 2]),
		.count(fan_a_cnt)
	);
	fan_period_counter fan_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.tach(tach_input_b),
		.div_code(fandiv[mon_pkg::FDIV_B_LSB +: 2]),
		.count(fan_b_cnt)
	);

	// bus decode; both write channels are taken at the same edge
	assign wr_fire = awvalid && awready && wvalid && wready;
	assign wr_idx = awaddr[9:2];
	assign wr_en = wr_fire && wstrb[0] && mapped(awaddr);
	assign rd_fire = arvalid && arready;
	assign rd_idx = araddr[9:2];
	assign rd_ok = mapped(araddr);
	assign rd_stat1 = rd_fire && rd_ok && rd_idx == mon_pkg::IDX_STAT1;
	assign rd_stat2 = rd_fire && rd_ok && rd_idx == mon_pkg::IDX_STAT2;
	assign rd_ext1 = rd_fire && rd_ok && rd_idx == mon_pkg::IDX_EXT1;

	// write address and data ready pulse once both are offered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
		end else begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready <= awvalid && wvalid && !awready && !bvalid;
		end
	end

	// write response; unmapped addresses answer with a slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= mon_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= mapped(awaddr) ? mon_pkg::RESP_OKAY : mon_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// read address ready pulses while no read data is pending
	always_ff @(posedge aclk) begin
		if (!aresetn) arready <= 1'b0;
		else arready <= arvalid && !arready && !rvalid;
	end

	// read data is captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= mon_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_ok ? mon_pkg::RESP_OKAY : mon_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// read mux; narrow registers sit in the low byte
	always_comb begin
		rd_word = '0;
		case (rd_idx)
			mon_pkg::IDX_TEMP: begin
				if (ext && tcfg[mon_pkg::TCFG_RES12])
					rd_word = {{20{temp_data[11]}}, temp_data};
				else
					rd_word = {{23{temp_data[11]}}, temp_data[11:3]};
			end
			mon_pkg::IDX_FAN_A_CNT: rd_word = {24'h000000, fan_a_cnt};
			mon_pkg::IDX_FAN_B_CNT: rd_word = {24'h000000, fan_b_cnt};
			mon_pkg::IDX_HIGH: rd_word = {24'h000000, high_sp};
			mon_pkg::IDX_HIHYST: rd_word = {24'h000000, upper_release_setpoint};
			mon_pkg::IDX_FAN_A_LIM: rd_word = {24'h000000, fan_a_lim};
			mon_pkg::IDX_FAN_B_LIM: rd_word = {24'h000000, fan_b_lim};
			mon_pkg::IDX_CONFIG: rd_word = {24'h000000, cfg};
			mon_pkg::IDX_STAT1: rd_word = {24'h000000, stat1};
			mon_pkg::IDX_STAT2: rd_word = {24'h000000, stat2};
			mon_pkg::IDX_MASK1: rd_word = {24'h000000, mask1};
			mon_pkg::IDX_MASK2: rd_word = {24'h000000, mask2};
			mon_pkg::IDX_FANDIV: rd_word = {24'h000000, fandiv};
			mon_pkg::IDX_TEMP_CFG: rd_word = {24'h000000, tcfg};
			mon_pkg::IDX_EXT1: rd_word = {24'h000000, ext1_ctl[7:1], crit_flag};
			mon_pkg::IDX_LOW: rd_word = {24'h000000, low_sp};
			mon_pkg::IDX_CRIT: rd_word = {24'h000000, critical_temp_setpoint};
			mon_pkg::IDX_HYST: rd_word = {29'h00000000, hysteresis_offset};
			default: rd_word = '0;
		endcase
		if (!rd_ok) rd_word = '0;
	end

	// software registers; self-clearing pulse bits are not kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= mon_pkg::RST_CONFIG;
			mask1 <= mon_pkg::RST_ZERO;
			mask2 <= mon_pkg::RST_ZERO;
			fandiv <= mon_pkg::RST_FANDIV;
			tcfg <= mon_pkg::RST_TEMP_CFG;
			ext1_ctl <= mon_pkg::RST_EXT1;
		end else if (wr_en) begin
			case (wr_idx)
				mon_pkg::IDX_CONFIG: cfg <= wdata[7:0] & mon_pkg::CFG_WR_MASK;
				mon_pkg::IDX_MASK1: mask1 <= wdata[7:0];
				mon_pkg::IDX_MASK2: mask2 <= wdata[7:0];
				mon_pkg::IDX_FANDIV: fandiv <= wdata[7:0] & mon_pkg::FANDIV_WR_MASK;
				mon_pkg::IDX_TEMP_CFG: tcfg <= wdata[7:0];
				mon_pkg::IDX_EXT1: ext1_ctl <= wdata[7:0];
				default: cfg <= cfg;
			endcase
		end
	end

	// limits and setpoints
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_sp <= mon_pkg::RST_HI_SET;
			upper_release_setpoint <= mon_pkg::RST_HI_SET;
			low_sp <= mon_pkg::RST_LO_SET;
			critical_temp_setpoint <= mon_pkg::RST_HI_SET;
			hysteresis_offset <= mon_pkg::RST_ZERO[2:0];
			fan_a_lim <= mon_pkg::RST_FAN_LIM;
			fan_b_lim <= mon_pkg::RST_FAN_LIM;
		end else if (wr_en) begin
			case (wr_idx)
				mon_pkg::IDX_HIGH: high_sp <= wdata[7:0];
				mon_pkg::IDX_HIHYST: upper_release_setpoint <= wdata[7:0];
				mon_pkg::IDX_LOW: low_sp <= wdata[7:0];
				mon_pkg::IDX_CRIT: critical_temp_setpoint <= wdata[7:0];
				mon_pkg::IDX_HYST: hysteresis_offset <= wdata[2:0];
				mon_pkg::IDX_FAN_A_LIM: fan_a_lim <= wdata[7:0];
				mon_pkg::IDX_FAN_B_LIM: fan_b_lim <= wdata[7:0];
				default: high_sp <= high_sp;
			endcase
		end
	end

	// monitoring halts while stopped or while the interrupt clear is held
	assign running = cfg[mon_pkg::CFG_START] && !cfg[mon_pkg::CFG_INT_CLR];
	assign conv_fire = conv_done && running;
	assign ext = tcfg[mon_pkg::TCFG_EXT];
	assign mode = mon_pkg::temp_mode_t'(tcfg[1:0]);
	assign cmp_mode = (mode != mon_pkg::MODE_REPEAT) && (mode != mon_pkg::MODE_ONCE);
	assign d = {{2{conv_data[11]}}, conv_data};
	assign th = to_cmp(high_sp, 3'h0, 1'b0);
	assign thh = to_cmp(upper_release_setpoint, 3'h0, 1'b0);
	assign tl = to_cmp(low_sp, 3'h0, 1'b0);
	assign tc = to_cmp(critical_temp_setpoint, 3'h0, 1'b0);

	// entry and leave points of the high, low and critical regions
	always_comb begin
		hi_enter = d > th;
		if (ext) hi_leave = d <= to_cmp(high_sp, hysteresis_offset, 1'b1);
		else if (cmp_mode) hi_leave = d <= th;
		else hi_leave = d <= thh;
		lo_enter = ext && d <= tl;
		// comparator release taken at low plus hysteresis
		lo_leave = d > to_cmp(low_sp, hysteresis_offset, 1'b0);
		cr_enter = ext && d > tc;
		// comparator release taken at crit minus hysteresis
		cr_leave = d <= to_cmp(critical_temp_setpoint, hysteresis_offset, 1'b1);
		hi_next = region(hi_enter, hi_leave, hi_reg);
		lo_next = ext && region(lo_enter, lo_leave, lo_reg);
		cr_next = ext && region(cr_enter, cr_leave, cr_reg);
	end

	// region memory advances once per conversion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_reg <= 1'b0;
			lo_reg <= 1'b0;
			cr_reg <= 1'b0;
			temp_data <= '0;
		end else if (conv_fire) begin
			hi_reg <= hi_next;
			lo_reg <= lo_next;
			cr_reg <= cr_next;
			temp_data <= conv_data;
		end
	end

	// status flags: an event in the clearing cycle survives the read
	always_comb begin
		next_stat1 = mon_pkg::RST_ZERO;
		next_stat2 = mon_pkg::RST_ZERO;
		next_stat1[mon_pkg::ST1_TEMP] = upd(stat1[mon_pkg::ST1_TEMP], rd_stat1, conv_fire,
			mode, hi_enter, hi_reg, hi_next);
		next_stat1[mon_pkg::ST1_FAN_A] = (stat1[mon_pkg::ST1_FAN_A] && !rd_stat1)
			|| (conv_fire && fan_a_cnt > fan_a_lim);
		next_stat1[mon_pkg::ST1_FAN_B] = (stat1[mon_pkg::ST1_FAN_B] && !rd_stat1)
			|| (conv_fire && fan_b_cnt > fan_b_lim);
		next_stat2[mon_pkg::ST2_INTR] = (stat2[mon_pkg::ST2_INTR] && !rd_stat2)
			|| intrusion_input;
		next_stat2[mon_pkg::ST2_TLOW] = upd(stat2[mon_pkg::ST2_TLOW], rd_stat2, conv_fire,
			mode, lo_enter, lo_reg, lo_next);
		next_crit = upd(crit_flag, rd_ext1, conv_fire, mode, cr_enter, cr_reg,
			cr_next);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat1 <= mon_pkg::RST_ZERO;
			stat2 <= mon_pkg::RST_ZERO;
			crit_flag <= 1'b0;
		end else begin
			stat1 <= next_stat1;
			stat2 <= next_stat2;
			crit_flag <= next_crit;
		end
	end

	// outputs are registered; masked flags still sit in status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_n <= 1'b1;
			critical_temp_alarm_n <= 1'b1;
		end else begin
			int_n <= !(cfg[mon_pkg::CFG_INT_EN] && !cfg[mon_pkg::CFG_INT_CLR]
				&& ((|(stat1 & ~mask1)) || (|(stat2 & ~mask2))));
			critical_temp_alarm_n <= !(crit_flag && ext);
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	alarm_normal_a: assert property (
		conv_fire && !ext |=> !crit_flag)
		else $error("critical flag set in a normal mode");
	int_mask_a: assert property (
		!int_n |-> $past(cfg[mon_pkg::CFG_INT_EN] && ((|(stat1 & ~mask1))
			|| (|(stat2 & ~mask2)))))
		else $error("interrupt without an unmasked flag");
	read_clear_a: assert property (
		rd_stat1 && !conv_done |=> stat1 == mon_pkg::RST_ZERO)
		else $error("status 1 not cleared by its read");
	once_hold_a: assert property (
		conv_fire && !ext && mode == mon_pkg::MODE_ONCE && hi_reg && d > thh
		&& !rd_stat1 |=> $stable(stat1[mon_pkg::ST1_TEMP]))
		else $error("one-time interrupt fired again without re-arming");
	compare_a: assert property (
		conv_fire && !ext && cmp_mode |=> stat1[mon_pkg::ST1_TEMP] == $past(d > th))
		else $error("comparator flag does not follow the upper setpoint");
	repeat_a: assert property (
		conv_fire && !ext && mode == mon_pkg::MODE_REPEAT && hi_reg && d > thh
		|=> stat1[mon_pkg::ST1_TEMP])
		else $error("repetitive interrupt not re-asserted");
	fan_flag_a: assert property (
		conv_fire && fan_a_cnt > fan_a_lim |=> stat1[mon_pkg::ST1_FAN_A])
		else $error("fan flag missed an over-limit count");
	intrusion_a: assert property (
		intrusion_input |=> stat2[mon_pkg::ST2_INTR] ##1 !int_n || mask2[mon_pkg::ST2_INTR]
		|| !cfg[mon_pkg::CFG_INT_EN] || cfg[mon_pkg::CFG_INT_CLR])
		else $error("intrusion did not reach status and interrupt");
	crit_out_a: assert property (
		crit_flag && ext |=> !critical_temp_alarm_n)
		else $error("alarm output not driven by the critical flag");
	crit_keep_a: assert property (
		crit_flag && !conv_done && !rd_ext1 |=> crit_flag)
		else $error("critical flag dropped without an ext read");

	temp_int_c: cover property (conv_fire && hi_enter ##[1:3] !int_n);
	crit_c: cover property (!critical_temp_alarm_n ##1 rd_ext1);
	low_c: cover property (conv_fire && ext && lo_enter);
	status_read_c: cover property (rd_stat1 && stat1 != mon_pkg::RST_ZERO);

endmodule : temp_fan_limit_irq

// ==== tb/far_side_model.sv ====
/*
 * far side of the monitor: two fan tachs and the temperature converter.
 * assumes the bench gives tach periods in aclk cycles (0 stops a fan)
 * and pulses conv_go for one cycle to end a conversion.
 */
`timescale 1ns/100ps
module far_side_model (
	input wire logic aclk,
	input wire logic [15:0] per_a,
	input wire logic [15:0] per_b,
	input wire logic conv_go,
	input wire logic [11:0] conv_val,
	output logic tach_input_a,
	output logic tach_input_b,
	output logic conv_done,
	output logic [11:0] conv_data
);
	logic [15:0] ca;
	logic [15:0] cb;
	initial begin
		{ca, cb, tach_input_a, tach_input_b, conv_done, conv_data} = '0;
	end
	// tach high for the first half of each period; a stopped fan stays low
	always @(posedge aclk) begin
		ca <= (ca + 16'h1 >= per_a) ? 16'h0 : ca + 16'h1;
		cb <= (cb + 16'h1 >= per_b) ? 16'h0 : cb + 16'h1;
		tach_input_a <= (per_a != 16'h0) && (ca < per_a / 2);
		tach_input_b <= (per_b != 16'h0) && (cb < per_b / 2);
	end
	// data means nothing outside the done pulse, so it churns there
	always @(posedge aclk) begin
		conv_done <= conv_go;
		conv_data <= conv_go ? conv_val : ~conv_data;
	end
endmodule : far_side_model

// ==== tb/tb_temp_fan_limit_irq.sv ====
/*
 * bench for the monitor: AXI4-Lite tasks, temperature modes, fans.
 * assumes the far side model and a 10 MHz aclk.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_temp_fan_limit_irq;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic rready = 0, intrusion_input = 0, conv_go = 0, awready, wready, bvalid, arready;
	logic rvalid, int_n, critical_temp_alarm_n, tach_a, tach_b, conv_done;
	logic [11:0] awaddr = 0, araddr = 0, conv_val = 0, conv_data, tv;
	logic [31:0] wdata = 0, rdata, rd_v;
	logic [1:0] bresp, rresp, rd_r, wr_r;
	logic [15:0] per_a = 16'h0;
	logic [7:0] tbl_i [7] = '{8'h40, 8'h47, 8'h4b, 8'h4c, 8'h39, 8'h50, 8'h41};
	logic [7:0] tbl_e [7] = '{8'h08, 8'h50, 8'h01, 8'h44, 8'h7f, 8'h80, 8'h00};
	int n_fail = 0, check_count = 0, cyc = 0, seed = 89458, e;
	temp_fan_limit_irq dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.tach_input_a(tach_a), .tach_input_b(tach_b), .conv_done(conv_done),
		.conv_data(conv_data), .intrusion_input(intrusion_input), .int_n(int_n),
		.critical_temp_alarm_n(critical_temp_alarm_n));
	far_side_model far (.aclk(aclk), .per_a(per_a), .per_b(16'h0), .conv_go(conv_go),
		.conv_val(conv_val), .tach_input_a(tach_a), .tach_input_b(tach_b),
		.conv_done(conv_done), .conv_data(conv_data));
	initial begin
		forever #50 aclk = ~aclk;
	end
	// hang guard: the run needs about 60000 cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			final_report;
		end
	end
	// expected fan count: period over one base tick scaled by the divisor
	function automatic int fan_exp(input int per, input int code);
		return per / (mon_pkg::FAN_TICK_CYC << code);
	endfunction : fan_exp
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {2'h0, i, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		do @(posedge aclk); while (!(awready === 1 && wready === 1));
		awvalid <= 0;
		wvalid <= 0;
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1);
		wr_r = bresp;
		bready <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] i);
		@(posedge aclk);
		araddr <= {2'h0, i, 2'h0};
		arvalid <= 1;
		do @(posedge aclk); while (arready !== 1);
		arvalid <= 0;
		rready <= 1;
		do @(posedge aclk); while (rvalid !== 1);
		rd_v = rdata;
		rd_r = rresp;
		rready <= 0;
	endtask : rd
	// one conversion end, then time for flags and outputs to settle
	task automatic conv(input logic [11:0] v);
		@(posedge aclk);
		conv_go <= 1;
		conv_val <= v;
		@(posedge aclk);
		conv_go <= 0;
		repeat (5) @(posedge aclk);
	endtask : conv
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		per_a <= 16'((40 + {$random(seed)} % 8) * 2 * mon_pkg::FAN_TICK_CYC);
		for (int k = 0; k < 7; k++) begin
			rd(tbl_i[k]);
			`CHK("reset value", {24'h0, tbl_e[k]}, rd_v)
		end
		rd(8'h10);
		`CHK("unmapped resp", mon_pkg::RESP_SLVERR, rd_r)
		wr(8'h10, 8'h55);
		`CHK("unmapped wr resp", mon_pkg::RESP_SLVERR, wr_r)
		wr(8'h47, 8'h10);
		wr(8'h39, 8'h19);
		wr(8'h3a, 8'h14);
		wr(8'h51, 8'h28);
		wr(8'h40, 8'h03);
		`CHK("write resp", mon_pkg::RESP_OKAY, wr_r)
		$display("registers done");
		conv(12'h2d0);
		`CHK("int one-time", 1'b0, int_n)
		`CHK("alarm normal", 1'b1, critical_temp_alarm_n)
		rd(8'h41);
		`CHK("status1", 32'h10, rd_v)
		// the line follows the cleared flag one edge after the read
		@(posedge aclk);
		`CHK("int after read", 1'b1, int_n)
		conv(12'h1e0);
		`CHK("no refire", 1'b1, int_n)
		conv(12'h140);
		conv(12'h1e0);
		`CHK("rearmed", 1'b0, int_n)
		rd(8'h41);
		wr(8'h4b, 8'h00);
		conv(12'h1e0);
		rd(8'h41);
		conv(12'h1e0);
		`CHK("repeat", 1'b0, int_n)
		wr(8'h43, 8'h10);
		rd(8'h41);
		conv(12'h1e0);
		`CHK("masked int", 1'b1, int_n)
		rd(8'h41);
		`CHK("masked flag", 32'h10, rd_v)
		wr(8'h43, 8'h00);
		wr(8'h4b, 8'h02);
		// the setpoint itself and one step above it come first, then random data
		for (int k = 0; k < 5; k++) begin
			tv = (k == 0) ? 12'h190 : (k == 1) ? 12'h191 : 12'($random(seed));
			conv(tv);
			`CHK("compare", !($signed(tv) > 12'sh190), int_n)
			rd(8'h27);
			`CHK("temp 9-bit", {{23{tv[11]}}, tv[11:3]}, rd_v)
		end
		$display("normal modes done");
		wr(8'h4b, 8'h05);
		conv(12'h2d0);
		`CHK("alarm set", 1'b0, critical_temp_alarm_n)
		rd(8'h4c);
		@(posedge aclk);
		`CHK("alarm read clear", 1'b1, critical_temp_alarm_n)
		rd(8'h41);
		@(posedge aclk) intrusion_input <= 1;
		@(posedge aclk) intrusion_input <= 0;
		rd(8'h42);
		`CHK("intrusion flag", 32'h10, rd_v)
		// extended repetitive low limit: 10 C with 2 C of hysteresis, 12-bit reads
		wr(8'h50, 8'h0a);
		wr(8'h52, 8'h02);
		wr(8'h4b, 8'h0c);
		conv(12'h0a0);
		rd(8'h42);
		`CHK("low set", 32'h80, rd_v)
		conv(12'h0b0);
		rd(8'h42);
		`CHK("low refire", 32'h80, rd_v)
		rd(8'h27);
		`CHK("temp 12-bit", 32'h0b0, rd_v)
		conv(12'h0d0);
		rd(8'h42);
		`CHK("low released", 32'h00, rd_v)
		$display("extended and intrusion done");
		while (cyc < 60000) @(posedge aclk);
		rd(8'h28);
		e = fan_exp(per_a, 1);
		`CHK("fan a count", 1'b1, rd_v >= e - 1 && rd_v <= e + 1)
		rd(8'h29);
		`CHK("fan b stopped", 32'hff, rd_v)
		wr(8'h3b, 8'd30);
		conv(12'h000);
		rd(8'h41);
		`CHK("fan flag", 32'h40, rd_v)
		$display("fans done");
		final_report;
	end
endmodule : tb_temp_fan_limit_irq
